/* File: src/rectifier_control_supervisor.sv */
// Purpose: setpoint source, shutdown sequencing, LED and address straps of a rectifier
// Assumes: analog flags and strap codes arrive asynchronously; link on its own clock
// Notes: long counts are parameters so a bench can shorten them
// What this block does
// - hardware mode: setpoint from pin below 3 V, else default 52 V.
// - after a firmware output-voltage command the pin is ignored for good.
// - at power-up hold constant current up to 20 s before overload protection.
// - outside startup, shut down 3 s after overcurrent persists.
// - output below 5 V during overload shuts down at once.
// - limit above 10 V blinks LED; below 10 V in restart mode hiccups.
// - LED steady when on, off when off or latched.
// - overcurrent and overtemperature auto-restart unless firmware selects latch-off.
// - overvoltage retries after 1 s; three failed retries in 1 minute latch off.
// - fewer than four overvoltage shutdowns in the window reset the count.
// - latch-off ends by pin, operation, reinsertion, AC cycle or restart config.
// - those restarts except reconfiguration need at least 2 s off.
// - successful restart clears alarms and sets the restart-successful status bit.
// - protocol strap open means I2C, resistor to return means RS485.
// - respond to address 100 plus four position bits, and broadcast 00.
// - four position bits come from unit and rack position straps.
// - unit strap decodes 3.00 V as 1 down to 0 V as 10; 3.30 V invalid.
// - map unit and rack positions to a four-bit code by the published grid.
// - broadcast is write only; broadcast read gets invalid-command.
`timescale 1ns/1ps
`default_nettype none
module rectifier_control_supervisor #(
    parameter longint START_CYC = supervisor_pkg::STARTUP_CC_CYC,
    parameter longint OC_CYC = supervisor_pkg::OC_DELAY_CYC,
    parameter longint RETRY_CYC = supervisor_pkg::OV_RETRY_CYC,
    parameter longint WIN_CYC = supervisor_pkg::OV_WINDOW_CYC,
    parameter longint OFF_CYC = supervisor_pkg::LATCH_OFF_CYC,
    parameter longint BLINK_CYC = supervisor_pkg::BLINK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic on_off_pin,
    input wire logic ac_ok,
    input wire logic present,
    input wire logic oc_det,
    input wire logic ot_det,
    input wire logic ov_det,
    input wire logic in_limit,
    input wire logic vout_gt_10v,
    input wire logic vout_gt_5v,
    input wire logic [supervisor_pkg::ADC_W-1:0] unit_position_pin,
    input wire logic [supervisor_pkg::ADC_W-1:0] rack_position_pin,
    input wire logic [supervisor_pkg::ADC_W-1:0] protocol_pin,
    input wire logic [supervisor_pkg::ADC_W-1:0] vprog_pin,
    input wire logic status_clr,
    input wire logic frame_valid,
    input wire logic [7:0] frame_addr,
    input wire logic [7:0] frame_cmd,
    input wire logic [15:0] frame_data,
    output logic link_ack_ff,
    output logic link_nak_ff,
    output logic out_on_ff,
    output logic led_ff,
    output logic cc_mode_ff,
    output logic latched_ff,
    output logic restart_ok_ff,
    output logic clear_alarms_ff,
    output supervisor_pkg::vsrc_t vsel_ff,
    output logic [15:0] vout_word_ff,
    output logic i2c_mode_ff,
    output logic addr_ok_ff,
    output logic [3:0] position_address_bits_ff
);
    import supervisor_pkg::*;

    localparam logic [TW-1:0] T_START = TW'(START_CYC);
    localparam logic [TW-1:0] T_OC = TW'(OC_CYC);
    localparam logic [TW-1:0] T_RETRY = TW'(RETRY_CYC);
    localparam logic [TW-1:0] T_WIN = TW'(WIN_CYC);
    localparam logic [TW-1:0] T_OFF = TW'(OFF_CYC);
    localparam logic [TW-1:0] T_BLINK = TW'(BLINK_CYC);
    localparam int AW = 4 * ADC_W;

    // voltage in mV of an 8-bit code
    function automatic int to_mv(input logic [ADC_W-1:0] c);
        return int'(c) * ADC_FS_MV / ADC_FS_CODE;
    endfunction

    // 0 = invalid, 1..10 positions
    function automatic int unit_pos(input logic [ADC_W-1:0] c);
        int p;
        p = 0;
        for (int i = 1; i < 11; i++)
            if (to_mv(c) < (UNIT_MV[i-1] + UNIT_MV[i]) / 2)
                p = i;
        return p;
    endfunction

    function automatic int rack_pos(input logic [ADC_W-1:0] c);
        int p;
        p = 1;
        for (int i = 1; i < 8; i++)
            if (to_mv(c) < (RACK_MV[i-1] + RACK_MV[i]) / 2)
                p = i + 1;
        return p;
    endfunction

    // bit 4 flags a valid position pair
    function automatic logic [4:0] addr_map(input int u, input int r);
        int a;
        a = -1;
        if (u >= 1 && u <= 4 && r <= 4)
            a = (r - 1) * 4 + u - 1;
        else if (u >= 1 && u <= 5 && r >= 6)
            a = (r - 6) * 5 + u - 1;
        else if (u >= 6 && u <= 7)
            a = (r - 1) * 2 + u - 6;
        else if (u >= 8 && r >= 4)
            a = (r - 4) * 3 + u - 8;
        return (a < 0) ? 5'h00 : {1'b1, a[3:0]};
    endfunction

    logic [8:0] pin_meta_ff;
    logic [8:0] pin_ff;
    logic [AW-1:0] adc_meta_ff;
    logic [AW-1:0] adc_ff;
    logic req_meta_ff;
    logic req_sync_ff;
    logic ack_tgl_ff;
    logic req_tgl;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;

    always_ff @(posedge clk)
    begin
        pin_meta_ff <= {on_off_pin, ac_ok, present, oc_det, ot_det, ov_det,
                        in_limit, vout_gt_10v, vout_gt_5v};
        pin_ff <= pin_meta_ff;
        adc_meta_ff <= {unit_position_pin, rack_position_pin, protocol_pin, vprog_pin};
        adc_ff <= adc_meta_ff;
        req_meta_ff <= req_tgl;
        req_sync_ff <= req_meta_ff;
    end

    logic on_s, ac_s, pres_s, oc_s, ot_s, ov_s, lim_s, gt10_s, gt5_s;
    assign {on_s, ac_s, pres_s, oc_s, ot_s, ov_s, lim_s, gt10_s, gt5_s} = pin_ff;

    supervisor_link_port u_link (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .frame_valid(frame_valid),
        .frame_addr(frame_addr),
        .frame_cmd(frame_cmd),
        .frame_data(frame_data),
        .cfg_i2c(i2c_mode_ff),
        .cfg_ok(addr_ok_ff),
        .cfg_bits(position_address_bits_ff),
        .ack_tgl(ack_tgl_ff),
        .link_ack_ff(link_ack_ff),
        .link_nak_ff(link_nak_ff),
        .req_tgl_ff(req_tgl),
        .cmd_code_ff(cmd_code),
        .cmd_data_ff(cmd_data)
    );

    // strap capture and firmware command state
    logic [1:0] settle_ff, nxt_settle;
    logic strap_done_ff, nxt_strap_done;
    logic nxt_i2c, nxt_addr_ok;
    logic [3:0] nxt_pos;
    logic fw_vout_ff, nxt_fw_vout;
    logic [15:0] fw_val_ff, nxt_fw_val;
    logic op_on_ff, nxt_op_on;
    logic oc_latch_ff, nxt_oc_latch;
    logic ot_latch_ff, nxt_ot_latch;
    logic nxt_ack_tgl;
    vsrc_t nxt_vsel;
    logic [15:0] nxt_vout;
    logic [4:0] amap;
    logic cmd_ev;

    always_comb
    begin
        amap = addr_map(unit_pos(adc_ff[AW-1 -: ADC_W]), rack_pos(adc_ff[3*ADC_W-1 -: ADC_W]));
        cmd_ev = req_sync_ff != ack_tgl_ff;
        nxt_settle = settle_ff;
        nxt_strap_done = strap_done_ff;
        nxt_i2c = i2c_mode_ff;
        nxt_addr_ok = addr_ok_ff;
        nxt_pos = position_address_bits_ff;
        if (!strap_done_ff)
        begin
            nxt_settle = settle_ff + 2'h1;
            if (settle_ff == STRAP_SETTLE)
            begin
                nxt_strap_done = 1'b1;
                nxt_i2c = to_mv(adc_ff[2*ADC_W-1 -: ADC_W]) >= PROTO_MID_MV;
                nxt_addr_ok = amap[4];
                nxt_pos = amap[3:0];
            end
        end
        nxt_fw_vout = fw_vout_ff;
        nxt_fw_val = fw_val_ff;
        nxt_op_on = op_on_ff;
        nxt_oc_latch = oc_latch_ff;
        nxt_ot_latch = ot_latch_ff;
        nxt_ack_tgl = ack_tgl_ff;
        if (cmd_ev)
        begin
            nxt_ack_tgl = req_sync_ff;
            unique case (cmd_code)
                CMD_VOUT:
                begin
                    nxt_fw_vout = 1'b1;
                    nxt_fw_val = cmd_data;
                end
                CMD_OPERATION: nxt_op_on = cmd_data[OP_ON_BIT];
                CMD_OC_RESP: nxt_oc_latch = cmd_data[RESP_MODE_LSB +: 2] == RESP_LATCH;
                CMD_OT_RESP: nxt_ot_latch = cmd_data[RESP_MODE_LSB +: 2] == RESP_LATCH;
                default: ;
            endcase
        end
        if (fw_vout_ff)
        begin
            nxt_vsel = VSRC_FW;
            nxt_vout = fw_val_ff;
        end
        else if (to_mv(adc_ff[ADC_W-1:0]) < VPROG_MAX_MV)
        begin
            nxt_vsel = VSRC_PIN;
            nxt_vout = {{(16-ADC_W){1'b0}}, adc_ff[ADC_W-1:0]};
        end
        else
        begin
            nxt_vsel = VSRC_DEFAULT;
            nxt_vout = DEFAULT_VOUT_MV;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            settle_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            i2c_mode_ff <= 1'b0;
            addr_ok_ff <= 1'b0;
            position_address_bits_ff <= 4'h0;
            fw_vout_ff <= 1'b0;
            fw_val_ff <= 16'h0000;
            op_on_ff <= 1'b1;
            oc_latch_ff <= 1'b0;
            ot_latch_ff <= 1'b0;
            ack_tgl_ff <= 1'b0;
            vsel_ff <= VSRC_DEFAULT;
            vout_word_ff <= DEFAULT_VOUT_MV;
        end
        else
        begin
            settle_ff <= nxt_settle;
            strap_done_ff <= nxt_strap_done;
            i2c_mode_ff <= nxt_i2c;
            addr_ok_ff <= nxt_addr_ok;
            position_address_bits_ff <= nxt_pos;
            fw_vout_ff <= nxt_fw_vout;
            fw_val_ff <= nxt_fw_val;
            op_on_ff <= nxt_op_on;
            oc_latch_ff <= nxt_oc_latch;
            ot_latch_ff <= nxt_ot_latch;
            ack_tgl_ff <= nxt_ack_tgl;
            vsel_ff <= nxt_vsel;
            vout_word_ff <= nxt_vout;
        end
    end

    // protection sequencer
    pstate_t st_ff, nxt_st;
    reason_t rsn_ff, nxt_rsn;
    logic [TW-1:0] tmr_ff, nxt_tmr, win_ff, nxt_win, blk_ff, nxt_blk;
    logic [1:0] ovc_ff, nxt_ovc;
    logic retry_ff, nxt_retry, seen_off_ff, nxt_seen_off, blink_ff, nxt_blink;
    logic nxt_on, nxt_led, nxt_cc, nxt_latched, nxt_rok, nxt_clr;
    logic en, flt, hic;
    reason_t frsn;

    always_comb
    begin
        en = on_s && op_on_ff && ac_s && pres_s && strap_done_ff;
        hic = lim_s && !gt10_s && !oc_latch_ff;
        nxt_st = st_ff;
        nxt_rsn = rsn_ff;
        nxt_tmr = tmr_ff + TW'(1);
        nxt_retry = retry_ff;
        nxt_seen_off = seen_off_ff;
        nxt_clr = 1'b0;
        nxt_rok = restart_ok_ff && !status_clr;
        flt = 1'b0;
        frsn = RSN_OC;
        unique case (st_ff)
            ST_OFF:
                if (en)
                begin
                    nxt_st = ST_START;
                    nxt_tmr = '0;
                end
            ST_START, ST_RUN, ST_OC_WAIT:
            begin
                if (!en)
                    nxt_st = ST_OFF;
                else if (ov_s || ot_s)
                begin
                    flt = 1'b1;
                    frsn = ov_s ? RSN_OV : RSN_OT;
                end
                else if (st_ff == ST_START)
                begin
                    if (tmr_ff >= T_START)
                    begin
                        nxt_st = ST_RUN;
                        if (retry_ff)
                        begin
                            nxt_clr = 1'b1;
                            nxt_rok = 1'b1;
                            nxt_retry = 1'b0;
                        end
                    end
                end
                else if (oc_s && (!gt5_s || hic || (st_ff == ST_OC_WAIT && tmr_ff >= T_OC)))
                    flt = 1'b1;
                else if (st_ff == ST_RUN && oc_s)
                begin
                    nxt_st = ST_OC_WAIT;
                    nxt_tmr = '0;
                end
                else if (st_ff == ST_OC_WAIT && !oc_s)
                    nxt_st = ST_RUN;
            end
            ST_RETRY:
                if (!en)
                    nxt_st = ST_OFF;
                else if (tmr_ff >= T_RETRY && !(rsn_ff == RSN_OT && ot_s))
                begin
                    nxt_st = ST_START;
                    nxt_tmr = '0;
                    nxt_retry = 1'b1;
                end
            ST_LATCHED:
                if ((rsn_ff == RSN_OC && !oc_latch_ff) || (rsn_ff == RSN_OT && !ot_latch_ff))
                begin
                    nxt_st = ST_START;
                    nxt_tmr = '0;
                    nxt_retry = 1'b1;
                end
                else if (!en)
                begin
                    // a short off blip must not count as a restart
                    if (!seen_off_ff)
                        nxt_tmr = '0;
                    nxt_seen_off = 1'b1;
                end
                else if (seen_off_ff)
                begin
                    nxt_seen_off = 1'b0;
                    nxt_tmr = '0;
                    if (tmr_ff >= T_OFF)
                    begin
                        nxt_st = ST_START;
                        nxt_retry = 1'b1;
                    end
                end
        endcase
        nxt_ovc = ovc_ff;
        nxt_win = (ovc_ff != 2'h0) ? win_ff + TW'(1) : '0;
        if (ovc_ff != 2'h0 && win_ff >= T_WIN)
            nxt_ovc = 2'h0;
        if (flt)
        begin
            nxt_rsn = frsn;
            nxt_tmr = '0;
            nxt_seen_off = 1'b0;
            nxt_retry = 1'b0;
            nxt_st = ST_RETRY;
            if (frsn == RSN_OV)
            begin
                if (ovc_ff == OV_MAX_TRIES)
                begin
                    nxt_st = ST_LATCHED;
                    nxt_ovc = 2'h0;
                end
                else
                    nxt_ovc = ovc_ff + 2'h1;
            end
            else if ((frsn == RSN_OC && oc_latch_ff) || (frsn == RSN_OT && ot_latch_ff))
                nxt_st = ST_LATCHED;
        end
        nxt_blk = (blk_ff >= T_BLINK) ? '0 : blk_ff + TW'(1);
        nxt_blink = (blk_ff >= T_BLINK) ? !blink_ff : blink_ff;
        nxt_on = nxt_st == ST_START || nxt_st == ST_RUN || nxt_st == ST_OC_WAIT;
        nxt_led = nxt_on && (!(lim_s && gt10_s) || blink_ff);
        nxt_cc = nxt_st == ST_START && oc_s;
        nxt_latched = nxt_st == ST_LATCHED;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= ST_OFF;
            rsn_ff <= RSN_OC;
            tmr_ff <= '0;
            win_ff <= '0;
            blk_ff <= '0;
            ovc_ff <= 2'h0;
            retry_ff <= 1'b0;
            seen_off_ff <= 1'b0;
            blink_ff <= 1'b0;
            out_on_ff <= 1'b0;
            led_ff <= 1'b0;
            cc_mode_ff <= 1'b0;
            latched_ff <= 1'b0;
            restart_ok_ff <= 1'b0;
            clear_alarms_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            rsn_ff <= nxt_rsn;
            tmr_ff <= nxt_tmr;
            win_ff <= nxt_win;
            blk_ff <= nxt_blk;
            ovc_ff <= nxt_ovc;
            retry_ff <= nxt_retry;
            seen_off_ff <= nxt_seen_off;
            blink_ff <= nxt_blink;
            out_on_ff <= nxt_on;
            led_ff <= nxt_led;
            cc_mode_ff <= nxt_cc;
            latched_ff <= nxt_latched;
            restart_ok_ff <= nxt_rok;
            clear_alarms_ff <= nxt_clr;
        end
    end
endmodule
`default_nettype wire

/* File: src/supervisor_link_port.sv */
// Purpose: link-side address filter and command hand-off to the core clock
// Assumes: frame_* come from link-clock logic, one-cycle frame_valid
// Notes: one write in flight; a second write while busy is refused
`timescale 1ns/1ps
`default_nettype none
module supervisor_link_port (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic frame_valid,
    input wire logic [7:0] frame_addr,
    input wire logic [7:0] frame_cmd,
    input wire logic [15:0] frame_data,
    input wire logic cfg_i2c,
    input wire logic cfg_ok,
    input wire logic [3:0] cfg_bits,
    input wire logic ack_tgl,
    output logic link_ack_ff,
    output logic link_nak_ff,
    output logic req_tgl_ff,
    output logic [7:0] cmd_code_ff,
    output logic [15:0] cmd_data_ff
);
    import supervisor_pkg::*;

    logic [5:0] cfg_meta_ff;
    logic [5:0] cfg_ff;
    logic ack_meta_ff;
    logic ack_sync_ff;
    logic nxt_ack;
    logic nxt_nak;
    logic nxt_req;
    logic [7:0] nxt_code;
    logic [15:0] nxt_data;
    logic busy;
    logic bcast;
    logic mine;
    logic rd;

    // config is static after strap capture, so a plain two-stage sync is safe
    always_ff @(posedge link_clk)
    begin
        cfg_meta_ff <= {cfg_i2c, cfg_ok, cfg_bits};
        cfg_ff <= cfg_meta_ff;
        ack_meta_ff <= ack_tgl;
        ack_sync_ff <= ack_meta_ff;
    end

    always_comb
    begin
        rd = frame_addr[0];
        bcast = frame_addr[7:1] == BCAST_ADDR;
        mine = cfg_ff[4] && frame_addr[7:1] == {ADDR_HI, cfg_ff[3:0]};
        busy = req_tgl_ff != ack_sync_ff;
        nxt_ack = 1'b0;
        nxt_nak = 1'b0;
        nxt_req = req_tgl_ff;
        nxt_code = cmd_code_ff;
        nxt_data = cmd_data_ff;
        if (frame_valid && cfg_ff[5] && (bcast || mine))
        begin
            if (bcast && rd)
                nxt_nak = 1'b1;
            else if (rd)
                nxt_ack = 1'b1;
            else if (busy)
                nxt_nak = 1'b1;
            else
            begin
                nxt_ack = 1'b1;
                nxt_req = ~req_tgl_ff;
                nxt_code = frame_cmd;
                nxt_data = frame_data;
            end
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            link_ack_ff <= 1'b0;
            link_nak_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            cmd_code_ff <= 8'h00;
            cmd_data_ff <= 16'h0000;
        end
        else
        begin
            link_ack_ff <= nxt_ack;
            link_nak_ff <= nxt_nak;
            req_tgl_ff <= nxt_req;
            cmd_code_ff <= nxt_code;
            cmd_data_ff <= nxt_data;
        end
    end
endmodule
`default_nettype wire

/* File: src/supervisor_pkg.sv */
// Purpose: shared constants and types of the rectifier supervisor
// Assumes: 100 MHz core clock, 8-bit strap/setpoint codes, 0 V..3.3 V full scale
// Notes: times in ms, cycle counts derived from the clock rate
package supervisor_pkg;
    localparam longint CLK_KHZ = 100000;
    localparam int TW = 33;

    localparam longint STARTUP_CC_MS = 20000;
    localparam longint OC_DELAY_MS = 3000;
    localparam longint OV_RETRY_MS = 1000;
    localparam longint OV_WINDOW_MS = 60000;
    localparam longint LATCH_OFF_MS = 2000;
    localparam longint BLINK_MS = 500;
    localparam longint STARTUP_CC_CYC = STARTUP_CC_MS * CLK_KHZ;
    localparam longint OC_DELAY_CYC = OC_DELAY_MS * CLK_KHZ;
    localparam longint OV_RETRY_CYC = OV_RETRY_MS * CLK_KHZ;
    localparam longint OV_WINDOW_CYC = OV_WINDOW_MS * CLK_KHZ;
    localparam longint LATCH_OFF_CYC = LATCH_OFF_MS * CLK_KHZ;
    localparam longint BLINK_CYC = BLINK_MS * CLK_KHZ;
    localparam logic [1:0] OV_MAX_TRIES = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    localparam int ADC_W = 8;
    localparam int ADC_FS_MV = 3300;
    localparam int ADC_FS_CODE = 255;
    localparam int VPROG_MAX_MV = 3000;
    localparam int PROTO_MID_MV = 2200;
    localparam logic [15:0] DEFAULT_VOUT_MV = 16'hCB20;
    localparam int UNIT_MV [11] = '{3300, 3000, 2670, 2340, 2010, 1680, 1350, 1020, 690, 360, 0};
    localparam int RACK_MV [8] = '{3300, 2800, 2300, 1800, 1400, 1000, 500, 0};

    localparam logic [2:0] ADDR_HI = 3'h4;
    localparam logic [6:0] BCAST_ADDR = 7'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_VOUT = 8'h21;
    localparam logic [7:0] CMD_OC_RESP = 8'h47;
    localparam logic [7:0] CMD_OT_RESP = 8'h50;
    localparam int OP_ON_BIT = 7;
    localparam int RESP_MODE_LSB = 6;
    localparam logic [1:0] RESP_LATCH = 2'h2;

    typedef enum logic [1:0] {VSRC_DEFAULT, VSRC_PIN, VSRC_FW} vsrc_t;
    typedef enum logic [1:0] {RSN_OC, RSN_OT, RSN_OV} reason_t;
    typedef enum {ST_OFF, ST_START, ST_RUN, ST_OC_WAIT, ST_RETRY, ST_LATCHED} pstate_t;
endpackage

/* File: tb/link_host.sv */
// Purpose: link host model
// Assumes: falling-edge drive
// Notes: idle fields flip
`timescale 1ns/1ps
`default_nettype none
module link_host (
    input wire logic link_clk,
    input wire logic link_ack_ff,
    input wire logic link_nak_ff,
    output logic frame_valid,
    output logic [7:0] frame_addr,
    output logic [7:0] frame_cmd,
    output logic [15:0] frame_data
);
    logic [1:0] resp;
    initial
    begin
        frame_valid = 1'b0;
        {frame_addr, frame_cmd, frame_data} = '1;
    end
    task automatic send(input logic [6:0] a, input logic rd, input logic [7:0] c,
        input logic [15:0] d);
        @(negedge link_clk);
        frame_valid = 1'b1;
        frame_addr = {a, rd};
        frame_cmd = c;
        frame_data = d;
        @(negedge link_clk);
        resp = {link_ack_ff, link_nak_ff};
        frame_valid = 1'b0;
        {frame_addr, frame_cmd, frame_data} = ~{frame_addr, frame_cmd, frame_data};
        repeat (6) @(negedge link_clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/rcs_asserts.sv */
// Purpose: port checks
// Assumes: straps settle first
// Notes: straps read as static
`timescale 1ns/1ps
`default_nettype none
module rcs_asserts (
    input wire logic clk, rst, link_clk, link_rst, frame_valid, link_ack_ff, link_nak_ff,
    input wire logic i2c_mode_ff, addr_ok_ff, latched_ff, led_ff, out_on_ff,
    input wire logic clear_alarms_ff, restart_ok_ff,
    input wire logic [7:0] frame_addr,
    input wire logic [3:0] position_address_bits_ff,
    input wire logic [15:0] vout_word_ff,
    input wire supervisor_pkg::vsrc_t vsel_ff
);
    import supervisor_pkg::*;
    a_latch_dark: assert property (@(posedge clk) disable iff (rst)
        latched_ff && $past(latched_ff) |-> !led_ff && !out_on_ff) else $error("lit latched");
    a_fw_sticky: assert property (@(posedge clk) disable iff (rst)
        $past(vsel_ff) == VSRC_FW |-> vsel_ff == VSRC_FW) else $error("fw lost");
    a_default_word: assert property (@(posedge clk) disable iff (rst)
        vsel_ff == VSRC_DEFAULT |-> vout_word_ff == DEFAULT_VOUT_MV) else $error("default");
    a_restart_flag: assert property (@(posedge clk) disable iff (rst)
        clear_alarms_ff |-> ##[0:1] restart_ok_ff) else $error("no flag");
    a_bcast_read: assert property (@(posedge link_clk) disable iff (link_rst)
        frame_valid && frame_addr == 8'h01 && i2c_mode_ff |=> link_nak_ff && !link_ack_ff)
        else $error("bcast read");
    a_foreign_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        frame_valid && frame_addr[7:5] != ADDR_HI && frame_addr[7:1] != BCAST_ADDR
        |=> !link_ack_ff && !link_nak_ff) else $error("foreign");
    a_own_answer: assert property (@(posedge link_clk) disable iff (link_rst)
        frame_valid && frame_addr[7:1] == {ADDR_HI, position_address_bits_ff} && addr_ok_ff
        && i2c_mode_ff |=> link_ack_ff || link_nak_ff) else $error("unanswered");
    a_serial_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        frame_valid && !i2c_mode_ff |=> !link_ack_ff && !link_nak_ff) else $error("answered");
    c_latch: cover property (@(posedge clk) $rose(latched_ff));
    c_restart: cover property (@(posedge clk) clear_alarms_ff);
    c_nak: cover property (@(posedge link_clk) link_nak_ff);
endmodule
bind rectifier_control_supervisor rcs_asserts i_chk (.*);
`default_nettype wire

/* File: tb/rectifier_control_supervisor_tb_top.sv */
// Purpose: supervisor bench
// Assumes: short counts
// Notes: random setpoints
`timescale 1ns/1ps
`default_nettype none
module rectifier_control_supervisor_tb_top;
    import supervisor_pkg::*;
    logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, on_off_pin = 1'b0, status_clr = 1'b0;
    logic ac_ok = 1'b1, present = 1'b1, oc_det = 1'b0, ot_det = 1'b0, ov_det = 1'b0;
    logic in_limit = 1'b0, vout_gt_10v = 1'b1, vout_gt_5v = 1'b1;
    logic [7:0] unit_position_pin = 8'hCE, rack_position_pin = 8'hD8;
    logic [7:0] protocol_pin = 8'hFF, vprog_pin = 8'hFF, frame_addr, frame_cmd;
    logic frame_valid, link_ack_ff, link_nak_ff, out_on_ff, led_ff, cc_mode_ff, latched_ff;
    logic restart_ok_ff, clear_alarms_ff, i2c_mode_ff, addr_ok_ff;
    logic [15:0] frame_data, vout_word_ff;
    logic [3:0] position_address_bits_ff;
    vsrc_t vsel_ff;
    logic [31:0] seed = 32'h026FBEB5;
    int miscompares = 0, cmp_count = 0;
    wire link_rst = rst;
    always #5 clk = ~clk;
    always #32 link_clk = ~link_clk;
    rectifier_control_supervisor #(.START_CYC(200), .OC_CYC(50), .RETRY_CYC(40),
        .WIN_CYC(1000), .OFF_CYC(60), .BLINK_CYC(8)) i_dut (.clk, .rst, .link_clk, .link_rst,
        .on_off_pin, .ac_ok, .present, .oc_det, .ot_det, .ov_det, .in_limit, .vout_gt_10v,
        .vout_gt_5v, .unit_position_pin, .rack_position_pin, .protocol_pin, .vprog_pin,
        .status_clr, .frame_valid, .frame_addr, .frame_cmd, .frame_data, .link_ack_ff,
        .link_nak_ff, .out_on_ff, .led_ff, .cc_mode_ff, .latched_ff, .restart_ok_ff,
        .clear_alarms_ff, .vsel_ff, .vout_word_ff, .i2c_mode_ff, .addr_ok_ff,
        .position_address_bits_ff);
    link_host i_host (.link_clk, .link_ack_ff, .link_nak_ff, .frame_valid, .frame_addr,
        .frame_cmd, .frame_data);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #500000;
        miscompares++;
        summarize();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (40) @(negedge clk);
        chk(position_address_bits_ff, 4'h5);
        chk({addr_ok_ff, i2c_mode_ff}, 2'h3);
        chk(vout_word_ff, DEFAULT_VOUT_MV);
        unit_position_pin = 8'hE8;
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            vprog_pin = {1'b0, seed[6:0]};
            repeat (10) @(negedge clk);
            chk(vout_word_ff, {8'h00, vprog_pin});
        end
        i_host.send(BCAST_ADDR, 1'b1, CMD_OPERATION, 16'h0000);
        chk(i_host.resp, 2'h1);
        i_host.send(7'h30, 1'b0, CMD_VOUT, 16'h1234);
        chk(i_host.resp, 2'h0);
        i_host.send({ADDR_HI, 4'h5}, 1'b1, CMD_VOUT, 16'h0000);
        chk({i_host.resp, vsel_ff}, {2'h2, VSRC_PIN});
        seed = lfsr(seed);
        i_host.send({ADDR_HI, 4'h5}, 1'b0, CMD_VOUT, seed[15:0]);
        vprog_pin = 8'h10;
        repeat (20) @(negedge clk);
        chk(vout_word_ff, seed[15:0]);
        on_off_pin = 1'b1;
        oc_det = 1'b1;
        repeat (100) @(negedge clk);
        chk({out_on_ff, cc_mode_ff}, 2'h3);
        for (int i = 0; i < 400 && cc_mode_ff !== 1'b0; i++) @(negedge clk);
        repeat (30) @(negedge clk);
        chk(out_on_ff, 1'b1);
        repeat (30) @(negedge clk);
        chk(out_on_ff, 1'b0);
        oc_det = 1'b0;
        repeat (300) @(negedge clk);
        chk({out_on_ff, led_ff, restart_ok_ff}, 3'h7);
        status_clr = 1'b1;
        oc_det = 1'b1;
        vout_gt_5v = 1'b0;
        repeat (6) @(negedge clk);
        chk({out_on_ff, restart_ok_ff}, 2'h0);
        status_clr = 1'b0;
        oc_det = 1'b0;
        vout_gt_5v = 1'b1;
        ov_det = 1'b1;
        for (int i = 0; i < 3000 && latched_ff !== 1'b1; i++) @(negedge clk);
        chk({latched_ff, led_ff}, 2'h2);
        ov_det = 1'b0;
        ac_ok = 1'b0;
        repeat (100) @(negedge clk);
        ac_ok = 1'b1;
        for (int i = 0; i < 600 && restart_ok_ff !== 1'b1; i++) @(negedge clk);
        chk({latched_ff, out_on_ff, restart_ok_ff}, 3'h3);
        protocol_pin = 8'h00;
        rst = 1'b1;
        repeat (12) @(negedge clk); // spans a link edge
        rst = 1'b0;
        repeat (40) @(negedge clk);
        i_host.send({ADDR_HI, 4'h5}, 1'b0, CMD_VOUT, 16'h0001);
        chk({i_host.resp, i2c_mode_ff}, 3'h0);
        summarize();
    end
endmodule
`default_nettype wire
